// *** src/ahsb_consts.svh ***
`ifndef AHSB_CONSTS_SVH
`define AHSB_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave.
`define AHSB_OFS_CTRL 8'h00
`define AHSB_OFS_CMD0 8'h04
`define AHSB_OFS_CMD1 8'h08
`define AHSB_OFS_CMD2 8'h0C
`define AHSB_OFS_PLEN 8'h10
`define AHSB_OFS_HDR0 8'h14
`define AHSB_OFS_HDR1 8'h18
`define AHSB_OFS_STAT 8'h1C
`define AHSB_OFS_ADJ 8'h20

// Byte offsets of the header fields.
`define AHSB_HDR_RESULT_OFS 3'h0
`define AHSB_HDR_OPCODE_OFS 3'h2
`define AHSB_HDR_LENGTH_OFS 3'h4
`define AHSB_HDR_TAG_OFS 3'h6

// Result word field positions.
`define AHSB_RES_SEV_BIT 15
`define AHSB_RES_NS_HI 14
`define AHSB_RES_NS_LO 13
`define AHSB_RES_RSVD_BIT 12
`define AHSB_RES_CODE_HI 11

// Result namespaces.
`define AHSB_NS_PROTOCOL 2'h0
`define AHSB_NS_TECH 2'h1
`define AHSB_NS_DEVICE 2'h2

// Result codes.
`define AHSB_RESULT_OK 16'h0000
`define AHSB_RESULT_UNSUPPORTED 16'h8001
`define AHSB_RESULT_BAD_PARAMETER 16'h8002
`define AHSB_RESULT_BAD_ADDRESS 16'h8003
`define AHSB_RESULT_READ_ONLY 16'h8004
`define AHSB_RESULT_MISALIGNED 16'h8005
`define AHSB_RESULT_ACCESS_REFUSED 16'h8006
`define AHSB_RESULT_BUSY 16'h8007
`define AHSB_RESULT_ACK_TIMEOUT 16'h800B
`define AHSB_RESULT_BAD_HEADER 16'h800E
`define AHSB_RESULT_CONFIG_FORBIDS 16'h800F
`define AHSB_RESULT_GENERIC 16'h8FFF

// Command flag bits.
`define AHSB_FLAG_ACKREQ_BIT 14
`define AHSB_FLAG_RESEND_BIT 15
`define AHSB_FLAG_RSVD_MASK 16'h3FFF

// Opcode bit that marks an acknowledge.
`define AHSB_OPCODE_ACK_BIT 0

// Reset values.
`define AHSB_RST_WORD 32'h0000_0000
`define AHSB_RST_HALF 16'h0000

`endif

// *** src/ahsb_pkg.sv ***
package ahsb_pkg;
  typedef enum logic [1:0] {
    AHSB_IDLE = 2'b00,
    AHSB_BUILD = 2'b01,
    AHSB_DONE = 2'b10
  } ahsb_state_t;

  // Failure classes, in priority order (lowest number wins).
  typedef enum logic [3:0] {
    AHSB_FC_NONE = 4'h0,
    AHSB_FC_HEADER = 4'h1,
    AHSB_FC_UNSUPPORTED = 4'h2,
    AHSB_FC_BUSY = 4'h3,
    AHSB_FC_CONFIG = 4'h4,
    AHSB_FC_PARAMETER = 4'h5,
    AHSB_FC_ADDRESS = 4'h6,
    AHSB_FC_MISALIGNED = 4'h7,
    AHSB_FC_READ_ONLY = 4'h8,
    AHSB_FC_ACCESS = 4'h9,
    AHSB_FC_TIMEOUT = 4'hA,
    AHSB_FC_GENERIC = 4'hB
  } ahsb_fail_t;

  typedef struct packed {
    logic addrPhase;
    logic addrWrite;
    logic [7:0] addrOfs;
    logic [31:0] hrdata;
    ahsb_state_t state;
    logic [15:0] cmdFlags;
    logic [15:0] cmdOpcode;
    logic [15:0] cmdLength;
    logic [15:0] cmdTag;
    logic [15:0] payloadLength;
    logic [11:0] failBits;
    logic [11:0] adjustCode;
    logic adjustValid;
    logic [15:0] resultWord;
    logic [15:0] ackOpcode;
    logic [15:0] ackLength;
    logic [15:0] ackTag;
    logic ackValid;
    logic ackWanted;
    logic sticky;
  } ahsb_state_s_t;
endpackage

// *** src/ack_header_status_builder.sv ***
// What this block does
// R1: Result word sits at header byte offset zero.
// R2: Opcode field sits at header byte offset two.
// R3: Payload length field sits at header byte offset four.
// R4: Sequence tag sits at header byte offset six.
// R5: Host supplies the sequence tag and increments it per command.
// R6: Result word is 16 bits; code in bits 0-11; bit 12 zero.
// R7: Bits 13-14 carry namespace: protocol, technology or device.
// R8: Bit 15 is severity: zero warning or info, one error.
// R9: Adjusted writes report a warning result, not an error.
// R10: Success returns result word 0x0000.
// R11: Unimplemented or unknown opcode returns 0x8001.
// R12: Invalid or out of range parameter returns 0x8002.
// R13: Nonexistent register address returns 0x8003.
// R14: Write to read-only register returns 0x8004.
// R15: Misaligned access returns 0x8005.
// R16: Read of non-readable or write of non-writable returns 0x8006.
// R17: Busy receiver returns 0x8007.
// R18: Acknowledge wait timeout is reported as 0x800B.
// R19: Invalid header returns 0x800E.
// R20: Configuration forbidding the command returns 0x800F.
// R21: Acknowledge opcode has its least significant bit set.
// R22: Flag bit 14 requests an acknowledge from the receiver.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`include "ahsb_consts.svh"

module ack_header_status_builder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic ackValid,
  output logic ackWanted,
  output logic [63:0] ackHeader
);

  ahsb_pkg::ahsb_state_s_t cur, nxt;

  // Result word from a failure class, by priority.
  function automatic logic [15:0] resultFor(input logic [11:0] fails);
    logic [15:0] r;
    r = `AHSB_RESULT_OK; // R10
    if (fails[11]) r = `AHSB_RESULT_GENERIC;
    if (fails[10]) r = `AHSB_RESULT_ACK_TIMEOUT; // R18
    if (fails[9]) r = `AHSB_RESULT_ACCESS_REFUSED; // R16
    if (fails[8]) r = `AHSB_RESULT_READ_ONLY; // R14
    if (fails[7]) r = `AHSB_RESULT_MISALIGNED; // R15
    if (fails[6]) r = `AHSB_RESULT_BAD_ADDRESS; // R13
    if (fails[5]) r = `AHSB_RESULT_BAD_PARAMETER; // R12
    if (fails[4]) r = `AHSB_RESULT_CONFIG_FORBIDS; // R20
    if (fails[3]) r = `AHSB_RESULT_BUSY; // R17
    if (fails[2]) r = `AHSB_RESULT_UNSUPPORTED; // R11
    if (fails[1]) r = `AHSB_RESULT_BAD_HEADER; // R19
    return r;
  endfunction

  // Warning word: severity zero, device namespace, reserved bit zero.
  function automatic logic [15:0] warnWord(input logic [11:0] code);
    logic [15:0] w;
    w = 16'h0000;
    w[`AHSB_RES_CODE_HI:0] = code; // R6
    w[`AHSB_RES_RSVD_BIT] = 1'b0; // R6
    w[`AHSB_RES_NS_HI:`AHSB_RES_NS_LO] = `AHSB_NS_DEVICE; // R7
    w[`AHSB_RES_SEV_BIT] = 1'b0; // R8
    return w;
  endfunction

  logic [15:0] ctrlWord;
  logic [31:0] statWord;

  always_comb begin
    ctrlWord = {15'h0000, 1'b0};
    statWord = {12'h000, cur.state, cur.ackWanted, cur.ackValid, cur.resultWord};
  end

  always_comb begin
    logic isWriteAccess;
    logic adjOnly;
    isWriteAccess = 1'b0;
    adjOnly = 1'b0;
    nxt = cur;
    // Address phase capture; single-cycle slave, so hreadyout is always high.
    if (hready) begin
      nxt.addrPhase = hsel && htrans[1];
      nxt.addrWrite = hwrite;
      nxt.addrOfs = haddr[7:0];
    end
    if (cur.addrPhase && cur.addrWrite) begin
      isWriteAccess = 1'b1;
      case (cur.addrOfs)
        `AHSB_OFS_CMD0: begin
          nxt.cmdFlags = hwdata[31:16];
          nxt.cmdOpcode = hwdata[15:0];
        end
        `AHSB_OFS_CMD1: begin
          nxt.cmdLength = hwdata[31:16];
          nxt.cmdTag = hwdata[15:0];
        end
        `AHSB_OFS_CMD2: begin
          nxt.failBits = hwdata[11:0];
        end
        `AHSB_OFS_PLEN: begin
          nxt.payloadLength = hwdata[15:0];
        end
        `AHSB_OFS_ADJ: begin
          nxt.adjustCode = hwdata[11:0];
          nxt.adjustValid = hwdata[31];
        end
        `AHSB_OFS_CTRL: begin
          if (hwdata[0] && cur.state == ahsb_pkg::AHSB_IDLE) begin
            nxt.state = ahsb_pkg::AHSB_BUILD;
          end
          if (hwdata[1]) begin
            nxt.ackValid = 1'b0;
            nxt.state = ahsb_pkg::AHSB_IDLE;
          end
        end
        default: begin
          isWriteAccess = 1'b0;
        end
      endcase
    end
    // Read data for the data phase that begins next cycle.
    nxt.hrdata = 32'h0000_0000;
    if (hsel && htrans[1] && !hwrite && hready) begin
      case (haddr[7:0])
        `AHSB_OFS_CTRL: nxt.hrdata = {16'h0000, ctrlWord};
        `AHSB_OFS_CMD0: nxt.hrdata = {cur.cmdFlags, cur.cmdOpcode};
        `AHSB_OFS_CMD1: nxt.hrdata = {cur.cmdLength, cur.cmdTag};
        `AHSB_OFS_CMD2: nxt.hrdata = {20'h00000, cur.failBits};
        `AHSB_OFS_PLEN: nxt.hrdata = {16'h0000, cur.payloadLength};
        `AHSB_OFS_HDR0: nxt.hrdata = {cur.ackOpcode, cur.resultWord}; // R1 R2
        `AHSB_OFS_HDR1: nxt.hrdata = {cur.ackTag, cur.ackLength}; // R3 R4
        `AHSB_OFS_STAT: nxt.hrdata = statWord;
        `AHSB_OFS_ADJ: nxt.hrdata = {cur.adjustValid, 19'h00000, cur.adjustCode};
        default: nxt.hrdata = 32'h0000_0000;
      endcase
    end
    case (cur.state)
      ahsb_pkg::AHSB_IDLE: begin
      end
      ahsb_pkg::AHSB_BUILD: begin
        adjOnly = (cur.failBits == 12'h000) && cur.adjustValid;
        if (adjOnly) begin
          nxt.resultWord = warnWord(cur.adjustCode); // R9
        end else begin
          nxt.resultWord = resultFor(cur.failBits);
        end
        nxt.ackOpcode = {cur.cmdOpcode[15:1], 1'b1}; // R21
        // Errors carry no payload; a good answer carries the agreed length.
        nxt.ackLength = (cur.failBits == 12'h000) ? cur.payloadLength : 16'h0000; // R3
        nxt.ackTag = cur.cmdTag; // R4 R5
        nxt.ackWanted = cur.cmdFlags[`AHSB_FLAG_ACKREQ_BIT]; // R22
        nxt.ackValid = 1'b1;
        nxt.sticky = isWriteAccess;
        nxt.state = ahsb_pkg::AHSB_DONE;
      end
      ahsb_pkg::AHSB_DONE: begin
      end
      default: nxt.state = ahsb_pkg::AHSB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  always_comb begin
    hreadyout = 1'b1;
    hresp = 1'b0;
  end

  assign hrdata = cur.hrdata;
  assign ackValid = cur.ackValid;
  assign ackWanted = cur.ackWanted;
  // R1 R2 R3 R4: header bytes 0..7 with each field little-endian.
  assign ackHeader = {cur.ackTag, cur.ackLength, cur.ackOpcode, cur.resultWord};

  property p_ack_lsb;
    @(posedge clk) disable iff (!rst_n) ackValid |-> ackHeader[16];
  endproperty
  a_ack_lsb: assert property (p_ack_lsb) else $error("ack opcode lsb clear"); // R21

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rst_n) ackValid |-> !ackHeader[12];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("result reserved bit set"); // R6

  property p_ok;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && cur.failBits == 12'h000 && !cur.adjustValid)
      |=> ackHeader[15:0] == 16'h0000;
  endproperty
  a_ok: assert property (p_ok) else $error("success word wrong"); // R10

  property p_unsup;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && cur.failBits[2] && !cur.failBits[1])
      |=> ackHeader[15:0] == 16'h8001;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported code wrong"); // R11

  property p_hdr;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && cur.failBits[1]) |=> ackHeader[15:0] == 16'h800E;
  endproperty
  a_hdr: assert property (p_hdr) else $error("bad header code wrong"); // R19

  property p_warn;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && cur.failBits == 12'h000 && cur.adjustValid)
      |=> !ackHeader[15] && ackHeader[14:13] == 2'h2;
  endproperty
  a_warn: assert property (p_warn) else $error("adjust not a warning"); // R9

  property p_tag;
    @(posedge clk) disable iff (!rst_n)
      cur.state == ahsb_pkg::AHSB_BUILD |=> ackHeader[63:48] == $past(cur.cmdTag);
  endproperty
  a_tag: assert property (p_tag) else $error("tag not echoed"); // R4

  property p_ackreq;
    @(posedge clk) disable iff (!rst_n)
      cur.state == ahsb_pkg::AHSB_BUILD |=> ackWanted == $past(cur.cmdFlags[14]);
  endproperty
  a_ackreq: assert property (p_ackreq) else $error("ack request not copied"); // R22

  property p_err_sev;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && cur.failBits != 12'h000) |=> ackHeader[15];
  endproperty
  a_err_sev: assert property (p_err_sev) else $error("error lacks severity"); // R8

  // A start strobe in idle gives one build cycle, then a held answer.
  sequence s_start_build;
    cur.addrPhase && cur.addrWrite && cur.addrOfs == `AHSB_OFS_CTRL && hwdata[0] && !hwdata[1]
      && cur.state == ahsb_pkg::AHSB_IDLE;
  endsequence

  sequence s_building;
    cur.state == ahsb_pkg::AHSB_BUILD;
  endsequence

  sequence s_answered;
    ackValid && cur.state == ahsb_pkg::AHSB_DONE;
  endsequence

  property p_walk;
    @(posedge clk) disable iff (!rst_n) s_start_build |=> s_building ##1 s_answered;
  endproperty
  a_walk: assert property (p_walk) else $error("build walk broken"); // R1

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      (cur.addrPhase && cur.addrWrite && cur.addrOfs == `AHSB_OFS_CTRL && hwdata[1]
        && cur.state != ahsb_pkg::AHSB_BUILD)
      |=> !ackValid && cur.state == ahsb_pkg::AHSB_IDLE;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not drop the answer"); // R1

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_DONE && !(cur.addrPhase && cur.addrWrite))
      |=> $stable(ackHeader) && ackValid;
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed while held"); // R4

  property p_busy;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h00E) == 12'h008)
      |=> ackHeader[15:0] == 16'h8007;
  endproperty
  a_busy: assert property (p_busy) else $error("busy code wrong"); // R17

  property p_config;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h01E) == 12'h010)
      |=> ackHeader[15:0] == 16'h800F;
  endproperty
  a_config: assert property (p_config) else $error("config code wrong"); // R20

  property p_param;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h03E) == 12'h020)
      |=> ackHeader[15:0] == 16'h8002;
  endproperty
  a_param: assert property (p_param) else $error("parameter code wrong"); // R12

  property p_addr;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h07E) == 12'h040)
      |=> ackHeader[15:0] == 16'h8003;
  endproperty
  a_addr: assert property (p_addr) else $error("address code wrong"); // R13

  property p_align;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h0FE) == 12'h080)
      |=> ackHeader[15:0] == 16'h8005;
  endproperty
  a_align: assert property (p_align) else $error("alignment code wrong"); // R15

  property p_ronly;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h1FE) == 12'h100)
      |=> ackHeader[15:0] == 16'h8004;
  endproperty
  a_ronly: assert property (p_ronly) else $error("read only code wrong"); // R14

  property p_access;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h3FE) == 12'h200)
      |=> ackHeader[15:0] == 16'h8006;
  endproperty
  a_access: assert property (p_access) else $error("access code wrong"); // R16

  property p_timeout;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && (cur.failBits & 12'h7FE) == 12'h400)
      |=> ackHeader[15:0] == 16'h800B;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout code wrong"); // R18

  property p_ns_err;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && cur.failBits != 12'h000) |=> ackHeader[14:13] == 2'h0;
  endproperty
  a_ns_err: assert property (p_ns_err) else $error("error namespace wrong"); // R7

  property p_opcode;
    @(posedge clk) disable iff (!rst_n)
      cur.state == ahsb_pkg::AHSB_BUILD |=> ackHeader[31:17] == $past(cur.cmdOpcode[15:1]);
  endproperty
  a_opcode: assert property (p_opcode) else $error("opcode not echoed"); // R2

  property p_length;
    @(posedge clk) disable iff (!rst_n)
      (cur.state == ahsb_pkg::AHSB_BUILD && cur.failBits == 12'h000)
      |=> ackHeader[47:32] == $past(cur.payloadLength);
  endproperty
  a_length: assert property (p_length) else $error("payload length wrong"); // R3

endmodule

// *** tb/ahsb_host_model.sv ***
module ahsb_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdIssued,
  output logic [15:0] seqTag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] seqTag_reg;
  // Tags start at one after reset and step by one on each issued command.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqTag_reg <= 16'h0001;
    end else if (cmdIssued) begin
      seqTag_reg <= seqTag_reg + 16'h0001;
    end
  end
  assign seqTag = seqTag_reg;
endmodule

// *** tb/tb_ack_header_status_builder.sv ***
`include "ahsb_consts.svh"
module tb_ack_header_status_builder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic cmdIssued = 1'b0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic ackValid;
  logic ackWanted;
  logic [63:0] ackHeader;
  logic [15:0] seqTag;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] failCodes [1:11] = '{16'h800E, 16'h8001, 16'h8007, 16'h800F, 16'h8002,
    16'h8003, 16'h8005, 16'h8004, 16'h8006, 16'h800B, 16'h8FFF};

  ack_header_status_builder DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ackValid(ackValid),
    .ackWanted(ackWanted), .ackHeader(ackHeader));
  ahsb_host_model host (.clk(clk), .rst_n(rst_n), .cmdIssued(cmdIssued), .seqTag(seqTag));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    if (wr) hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ofs, d, x);
  endtask

  task automatic rdchk(input logic [7:0] ofs, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, ofs, 32'h0, x);
    check({32'h0, x}, {32'h0, e});
  endtask

  // Loads one command, builds its acknowledge, checks it and clears it again.
  task automatic build(input logic [15:0] flags, input logic [15:0] op, input logic [11:0] fails,
                       input logic [31:0] adj, input logic [15:0] plen, input logic [15:0] res);
    logic [15:0] tag;
    logic [15:0] len;
    tag = seqTag;
    len = res[15] ? 16'h0000 : plen;
    wr(`AHSB_OFS_CMD0, {flags, op});
    wr(`AHSB_OFS_CMD1, {plen, tag});
    wr(`AHSB_OFS_CMD2, {20'h00000, fails});
    wr(`AHSB_OFS_ADJ, adj);
    wr(`AHSB_OFS_PLEN, {16'h0000, plen});
    wr(`AHSB_OFS_CTRL, 32'h0000_0001);
    cmdIssued <= 1'b1;
    @(posedge clk);
    cmdIssued <= 1'b0;
    while (ackValid !== 1'b1) @(posedge clk);
    check(ackHeader, {tag, len, op | 16'h0001, res});
    check({63'h0, ackWanted}, {63'h0, flags[14]});
    rdchk(`AHSB_OFS_HDR0, {op | 16'h0001, res});
    rdchk(`AHSB_OFS_HDR1, {tag, len});
    rdchk(`AHSB_OFS_STAT, {12'h000, 2'h2, flags[14], 1'b1, res});
    wr(`AHSB_OFS_CTRL, 32'h0000_0002);
    @(posedge clk);
    check({63'h0, ackValid}, 64'h0);
  endtask

  task automatic t_reset();
    check({62'h0, hreadyout, hresp}, 64'h2);
    check({63'h0, ackValid}, 64'h0);
    check(ackHeader, 64'h0);
    $display("test reset done");
  endtask

  task automatic t_success();
    build(16'h4000, 16'h0800, 12'h000, 32'h0, 16'h000C, 16'h0000);
    build(16'h4000, 16'h0802, 12'h000, 32'h0, 16'h0000, 16'h0000);
    $display("test success done");
  endtask

  task automatic t_failures();
    for (int i = 1; i <= 11; i++) begin
      build({1'b0, i[0], 14'h0}, 16'h0C00, 12'h001 << i, 32'h0, 16'h0004,
            failCodes[i]);
    end
    build(16'h4000, 16'h0806, 12'h024, 32'h0, 16'h0008, 16'h8001);
    $display("test failures done");
  endtask

  task automatic t_adjust();
    build(16'h4000, 16'h0802, 12'h000, 32'h8000_0123, 16'h0000, 16'h4123);
    build(16'h4000, 16'h0802, 12'h020, 32'h8000_0123, 16'h0000, 16'h8002);
    $display("test adjust done");
  endtask

  task automatic t_unmapped();
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk(8'h40, 32'h0000_0000);
    check({63'h0, hresp}, 64'h0);
    $display("test unmapped done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_success();
    t_failures();
    t_adjust();
    t_unmapped();
    give_verdict();
  end
endmodule
